// File: common/dcbr_pkg.sv
// dcbr_pkg: shared constants and carrier types of the dual bus repeater
// assumes a single 40 MHz core clock, mclk
package dcbr_pkg;
  localparam int unsigned DCBR_CLK_HZ = 40000000;
  // dominant time-out, in milliseconds as printed
  localparam int unsigned DCBR_TDOM_MS = 25;
  localparam int unsigned DCBR_TDOM_CYC = DCBR_TDOM_MS * (DCBR_CLK_HZ / 1000);
  // feedback-suppression release delay, in cycles
  localparam int unsigned DCBR_FBS_CYC = 16;
  localparam int unsigned DCBR_TMR_W = 21;
  localparam int unsigned DCBR_FBS_W = 8;
  localparam int unsigned DCBR_SYNC_STAGES = 3;
  localparam int unsigned DCBR_NPATH = 4;
  // timer path indices
  localparam int unsigned DCBR_P_LOCAL = 0;
  localparam int unsigned DCBR_P_EXP = 1;
  localparam int unsigned DCBR_P_RX1 = 2;
  localparam int unsigned DCBR_P_RX2 = 3;
  // pin levels: low is dominant
  localparam logic DCBR_DOM = 1'h0;
  localparam logic DCBR_REC = 1'h1;

  // raw pin inputs, all active-low dominant or high-disable
  typedef struct packed {
    logic localTxIn;
    logic expTxIn;
    logic bus1RxIn;
    logic bus2RxIn;
    logic bus1DisableIn;
    logic bus2DisableIn;
  } dcbr_pins_t;

  // digital outputs
  typedef struct packed {
    logic localRxOut;
    logic expRxOut;
    logic bus1TxOut;
    logic bus2TxOut;
  } dcbr_outs_t;
endpackage

// File: rtl/dcbr_dom_timer.sv
// dcbr_dom_timer: dominant time-out filter for one active-low path
// assumes input is already synchronous to mclk
`timescale 1ns/1ps
module dcbr_dom_timer
  import dcbr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sigIn,
  output logic sigOut
);
  logic [DCBR_TMR_W-1:0] cnt_q;
  logic expired_q;

  // count while dominant, restart on recessive
  always_ff @(posedge mclk) begin
    if (!rst_n || sigIn == DCBR_REC) begin
      cnt_q <= '0;
      expired_q <= 1'h0;
    end else if (cnt_q >= DCBR_TMR_W'(DCBR_TDOM_CYC - 1)) begin
      expired_q <= 1'h1; // saturate, no wrap back to dominant
    end else begin
      cnt_q <= cnt_q + DCBR_TMR_W'(1);
    end
  end

  assign sigOut = (expired_q || !rst_n) ? DCBR_REC : sigIn;
endmodule

// File: rtl/dcbr_repeater.sv
// dcbr_repeater: logic unit of a dual CAN transceiver with repeater
// assumes comparators and drivers are analog; pins come in async
`timescale 1ns/1ps
module dcbr_repeater
  import dcbr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire dcbr_pins_t pins,
  input wire logic thermal_shutdown,
  output dcbr_outs_t outs,
  output logic bus1DriveEn,
  output logic bus2DriveEn
);
  logic [DCBR_SYNC_STAGES-1:0] syncLocal_q;
  logic [DCBR_SYNC_STAGES-1:0] syncExp_q;
  logic [DCBR_SYNC_STAGES-1:0] syncRx1_q;
  logic [DCBR_SYNC_STAGES-1:0] syncRx2_q;
  logic [DCBR_SYNC_STAGES-1:0] syncDis1_q;
  logic [DCBR_SYNC_STAGES-1:0] syncDis2_q;
  logic [DCBR_SYNC_STAGES-1:0] syncTsd_q;
  logic localIn_q;
  logic expIn_q;
  logic rx1In_q;
  logic rx2In_q;
  logic bus1_disable;
  logic bus2_disable;
  logic tsd_q;
  logic [DCBR_NPATH-1:0] pathIn;
  logic [DCBR_NPATH-1:0] pathOut;
  logic rx1Gated;
  logic rx2Gated;
  logic rx1Eff;
  logic rx2Eff;
  logic drive1_d;
  logic drive2_d;
  logic drive1_q;
  logic drive2_q;
  logic [DCBR_FBS_W-1:0] mask1Cnt_q;
  logic [DCBR_FBS_W-1:0] mask2Cnt_q;
  logic mask1;
  logic mask2;
  logic localRx_d;
  logic expRx_d;

  // three-stage synchronisers; a change counts when stages 2 and 3 agree
  // reset loads high, thermal low, so floating looks recessive
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      syncLocal_q <= '1;
      syncExp_q <= '1;
      syncRx1_q <= '1;
      syncRx2_q <= '1;
      syncDis1_q <= '1;
      syncDis2_q <= '1;
      syncTsd_q <= '0;
    end else begin
      syncLocal_q <= {syncLocal_q[1:0], pins.localTxIn};
      syncExp_q <= {syncExp_q[1:0], pins.expTxIn};
      syncRx1_q <= {syncRx1_q[1:0], pins.bus1RxIn};
      syncRx2_q <= {syncRx2_q[1:0], pins.bus2RxIn};
      syncDis1_q <= {syncDis1_q[1:0], pins.bus1DisableIn};
      syncDis2_q <= {syncDis2_q[1:0], pins.bus2DisableIn};
      syncTsd_q <= {syncTsd_q[1:0], thermal_shutdown};
    end
  end

  // agreement filter on stages 2 and 3, else hold last value
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      localIn_q <= DCBR_REC;
      expIn_q <= DCBR_REC;
      rx1In_q <= DCBR_REC;
      rx2In_q <= DCBR_REC;
      bus1_disable <= 1'h1;
      bus2_disable <= 1'h1;
      tsd_q <= 1'h0;
    end else begin
      if (syncLocal_q[1] == syncLocal_q[2]) localIn_q <= syncLocal_q[2];
      if (syncExp_q[1] == syncExp_q[2]) expIn_q <= syncExp_q[2];
      if (syncRx1_q[1] == syncRx1_q[2]) rx1In_q <= syncRx1_q[2];
      if (syncRx2_q[1] == syncRx2_q[2]) rx2In_q <= syncRx2_q[2];
      if (syncDis1_q[1] == syncDis1_q[2]) bus1_disable <= syncDis1_q[2];
      if (syncDis2_q[1] == syncDis2_q[2]) bus2_disable <= syncDis2_q[2];
      if (syncTsd_q[1] == syncTsd_q[2]) tsd_q <= syncTsd_q[2];
    end
  end

  assign rx1Gated = bus1_disable ? DCBR_REC : rx1In_q;
  assign rx2Gated = bus2_disable ? DCBR_REC : rx2In_q;

  // mask also covers the release delay
  assign rx1Eff = (mask1 || drive1_q) ? DCBR_REC : rx1Gated;
  assign rx2Eff = (mask2 || drive2_q) ? DCBR_REC : rx2Gated;

  assign pathIn[DCBR_P_LOCAL] = localIn_q;
  assign pathIn[DCBR_P_EXP] = expIn_q;
  assign pathIn[DCBR_P_RX1] = rx1Eff;
  assign pathIn[DCBR_P_RX2] = rx2Eff;

  genvar gi;
  generate
    for (gi = 0; gi < DCBR_NPATH; gi++) begin : gTmr
      dcbr_dom_timer uTmr (
        .mclk(mclk),
        .rst_n(rst_n),
        .sigIn(pathIn[gi]),
        .sigOut(pathOut[gi])
      );
    end
  endgenerate

  // dominant requests seen after the time-out filters
  // a timed-out path reads recessive here, so every consumer below
  // sees the same filtered level and no path can bypass its timer
  // low on a path output means dominant
  logic localReq;
  logic expReq;
  logic rx1Req;
  logic rx2Req;

  assign localReq = (pathOut[DCBR_P_LOCAL] == DCBR_DOM);
  assign expReq = (pathOut[DCBR_P_EXP] == DCBR_DOM);
  assign rx1Req = (pathOut[DCBR_P_RX1] == DCBR_DOM);
  assign rx2Req = (pathOut[DCBR_P_RX2] == DCBR_DOM);

  // transmit request shared by both transmitters
  // either tx input drives enabled buses
  logic txReq;

  assign txReq = localReq || expReq;

  // relay requests: a bus receiver feeds the other bus only
  // driving the source bus as well would mask its own receiver
  // at once, drop the relay and leave a one-cycle pulse train
  // on the far bus; the source bus is dominant already anyway
  // received dominant ends up on both buses
  logic relayTo1;
  logic relayTo2;

  assign relayTo1 = rx2Req;
  assign relayTo2 = rx1Req;

  // transmitter switch-on, one term per bus
  // any one of disable, thermal flag, timer or logic turns it off
  // disabled bus never driven
  // thermal, timer and logic force passive
  always_comb begin
    drive1_d = !bus1_disable && !tsd_q && (txReq || relayTo1);
    drive2_d = !bus2_disable && !tsd_q && (txReq || relayTo2);
  end

  // registered drive state of bus 1
  // drivers active only for dominant
  // each bus kept on its own terms
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      drive1_q <= 1'h0;
    end else begin
      drive1_q <= drive1_d;
    end
  end

  // registered drive state of bus 2
  // drivers active only for dominant
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      drive2_q <= 1'h0;
    end else begin
      drive2_q <= drive2_d;
    end
  end

  // release delay of bus 1: reloaded every cycle we drive, then counts
  // down; the delay must exceed the sync plus filter latency, or our own
  // trailing edge would come back as received dominant
  // receiver masked after drive ends
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask1Cnt_q <= '0;
    end else if (drive1_q) begin
      mask1Cnt_q <= DCBR_FBS_W'(DCBR_FBS_CYC);
    end else if (mask1Cnt_q != '0) begin
      mask1Cnt_q <= mask1Cnt_q - DCBR_FBS_W'(1);
    end
  end

  // release delay of bus 2, same scheme as bus 1
  // receiver masked after drive ends
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask2Cnt_q <= '0;
    end else if (drive2_q) begin
      mask2Cnt_q <= DCBR_FBS_W'(DCBR_FBS_CYC);
    end else if (mask2Cnt_q != '0) begin
      mask2Cnt_q <= mask2Cnt_q - DCBR_FBS_W'(1);
    end
  end

  // mask flags, live for the whole release delay
  assign mask1 = (mask1Cnt_q != '0);
  assign mask2 = (mask2Cnt_q != '0);

  // receive outputs use the masked bus paths, so a bus we drive for a
  // transmit request never echoes back as received dominant
  // limitation: a far node dominant on a bus we are driving is hidden
  // until the release delay ends; the tx path covers the local output
  // bus dominant pulls both outputs low
  // expansion tx reaches local output only
  always_comb begin
    localRx_d = !(localReq || expReq || rx1Req || rx2Req);
    expRx_d = !(localReq || rx1Req || rx2Req);
  end

  // output register; tx level follows the same edge as drive_q, so the
  // mask starts no later than our dominant shows on the bus
  // reset holds buses recessive, local receive high
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      outs <= '{localRxOut: DCBR_REC, expRxOut: DCBR_REC,
                bus1TxOut: DCBR_REC, bus2TxOut: DCBR_REC};
    end else begin
      outs.localRxOut <= localRx_d;
      outs.expRxOut <= expRx_d;
      outs.bus1TxOut <= !drive1_d;
      outs.bus2TxOut <= !drive2_d;
    end
  end

  // driver enable mirrors the registered tx level
  // high only while dominant is driven, passive otherwise
  assign bus1DriveEn = !outs.bus1TxOut;
  assign bus2DriveEn = !outs.bus2TxOut;
endmodule

// File: bench/dcbr_bus_model.sv
// dcbr_bus_model: wired bus level seen by each receiver
// assumes drive enables are high while the block drives dominant
`timescale 1ns/1ps
module dcbr_bus_model (
  input wire logic drv1,
  input wire logic drv2,
  input wire logic ext1,
  input wire logic ext2,
  output logic rx1,
  output logic rx2
);
  // any active driver beats recessive; low means dominant
  // dominant overrides
  assign rx1 = !(drv1 || ext1);
  assign rx2 = !(drv2 || ext2);
endmodule

// File: bench/dcbr_repeater_monitor.sv
// checker: port relations of the repeater
// assumes bind onto dcbr_repeater, one clock domain
`timescale 1ns/1ps
module dcbr_repeater_monitor
  import dcbr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire dcbr_pins_t pins,
  input wire logic thermal_shutdown,
  input wire dcbr_outs_t outs,
  input wire logic bus1DriveEn,
  input wire logic bus2DriveEn
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // other node dominant on bus1, both buses enabled
  sequence s_bus1Dom;
    (pins.localTxIn && pins.expTxIn && !thermal_shutdown &&
     !pins.bus1DisableIn && !pins.bus2DisableIn && !pins.bus1RxIn &&
     !bus1DriveEn)[*8];
  endsequence
  sequence s_localDom;
    (!pins.localTxIn)[*7];
  endsequence
  drive_en_mirror_a: assert property (
    bus1DriveEn == !outs.bus1TxOut && bus2DriveEn == !outs.bus2TxOut)
    else $error("drive enable differs from tx level");
  reset_idle_a: assert property (disable iff (1'b0)
    !rst_n |=> outs == 4'hf && !bus1DriveEn && !bus2DriveEn)
    else $error("outputs not idle after reset");
  bus1_off_a: assert property (pins.bus1DisableIn[*7] |-> !bus1DriveEn)
    else $error("disabled bus1 driven");
  bus2_off_a: assert property (pins.bus2DisableIn[*7] |-> !bus2DriveEn)
    else $error("disabled bus2 driven");
  thermal_off_a: assert property (
    thermal_shutdown[*7] |-> !bus1DriveEn && !bus2DriveEn)
    else $error("driver on during overtemperature");
  local_rx_a: assert property (
    s_localDom |-> !outs.localRxOut && !outs.expRxOut)
    else $error("local tx not seen on receive outputs");
  exp_rx_a: assert property ((
    !pins.expTxIn && pins.localTxIn && pins.bus1DisableIn &&
    pins.bus2DisableIn)[*7] |-> !outs.localRxOut && outs.expRxOut)
    else $error("expansion tx misrouted");
  relay_dom_a: assert property (
    s_bus1Dom ##1 s_bus1Dom ##1 s_bus1Dom |-> bus2DriveEn && !outs.expRxOut)
    else $error("bus1 dominant not relayed");
endmodule

bind dcbr_repeater dcbr_repeater_monitor mon (.mclk(mclk), .rst_n(rst_n),
  .pins(pins), .thermal_shutdown(thermal_shutdown), .outs(outs),
  .bus1DriveEn(bus1DriveEn), .bus2DriveEn(bus2DriveEn));

// File: bench/dcbr_repeater_test.sv
// testbench: directed scenarios on the repeater logic
// assumes the 25 ms time-out is out of reach of a short run
`timescale 1ns/1ps
module dcbr_repeater_test;
  import dcbr_pkg::*;
  logic mclk, rst_n, lt, et, d1, d2, th, x1, x2, r1, r2, en1, en2;
  dcbr_pins_t pins;
  dcbr_outs_t outs;
  int n_errors, compares;
  assign pins = '{lt, et, r1, r2, d1, d2};
  dcbr_repeater DUT (.mclk(mclk), .rst_n(rst_n), .pins(pins),
    .thermal_shutdown(th), .outs(outs), .bus1DriveEn(en1),
    .bus2DriveEn(en2));
  dcbr_bus_model far (.drv1(en1), .drv2(en2), .ext1(x1), .ext2(x2),
    .rx1(r1), .rx2(r2));
  // 40 MHz clock
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end
  task chk(input string nm, input logic [5:0] seen, input logic [5:0] e);
    compares++;
    if (seen !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
    end
  endtask
  // wait past sync and suppression delay, then compare
  task look(input string nm, input logic [5:0] e);
    repeat (24) @(negedge mclk);
    chk(nm, {outs, en1, en2}, e);
  endtask
  task t_local;
    lt = 1'h0;
    look("local", 6'h03);
    lt = 1'h1;
    look("localEnd", 6'h3c);
  endtask
  task t_exp;
    et = 1'h0;
    look("exp", 6'h13);
    et = 1'h1;
    look("expEnd", 6'h3c);
  endtask
  task t_dis;
    d1 = 1'h1;
    d2 = 1'h1;
    lt = 1'h0;
    look("disTx", 6'h0c);
    lt = 1'h1;
    et = 1'h0;
    look("disExp", 6'h1c);
    et = 1'h1;
    x1 = 1'h1;
    look("disRx", 6'h3c);
    x1 = 1'h0;
    d1 = 1'h0;
    d2 = 1'h0;
    look("disEnd", 6'h3c);
  endtask
  task t_relay;
    d2 = 1'h1;
    x1 = 1'h1;
    look("relay1", 6'h0c);
    d2 = 1'h0;
    look("relay2", 6'h09);
    x1 = 1'h0;
    look("relayEnd", 6'h3c);
    x2 = 1'h1;
    look("relay21", 6'h06);
    x2 = 1'h0;
    look("relay21End", 6'h3c);
  endtask
  task t_therm;
    th = 1'h1;
    lt = 1'h0;
    look("therm", 6'h0c);
    lt = 1'h1;
    th = 1'h0;
    look("thermEnd", 6'h3c);
  endtask
  task report_and_stop;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    n_errors = 0;
    compares = 0;
    {lt, et, d1, d2, th, x1, x2} = 7'h60;
    rst_n = 1'h0;
    repeat (3) @(negedge mclk);
    chk("reset", {outs, en1, en2}, 6'h3c);
    @(negedge mclk);
    rst_n = 1'h1;
    look("idle", 6'h3c);
    t_local;
    t_exp;
    t_dis;
    t_relay;
    t_therm;
    report_and_stop;
  end
endmodule
